//--- rtl/lse_map.svh
// register map, field positions, reset values and timing of the enable logic
`ifndef LSE_MAP_SVH
`define LSE_MAP_SVH
`define LSE_OFS_PG_MASK_A  8'h22
`define LSE_OFS_PIN_PG_CFG 8'h23
`define LSE_OFS_EDGE_DLY   8'h24
`define LSE_RST_PG_MASK_A  8'h00
`define LSE_RST_PIN_PG_CFG 8'h80
`define LSE_RST_EDGE_DLY   8'h00
`define LSE_RD_UNMAPPED    8'h00
`define LSE_BIT_MASK_LDO2  7
`define LSE_BIT_MASK_SWA   6
`define LSE_BUCK_HI        5
`define LSE_BUCK_LO        0
`define LSE_BIT_MASK_SWB2  1
`define LSE_BIT_MASK_LDO3  0
`define LSE_SRC_HI         4
`define LSE_SRC_LO         2
`define LSE_PGT_HI         6
`define LSE_PGT_LO         5
`define LSE_FALL_HI        5
`define LSE_FALL_LO        3
`define LSE_RISE_HI        2
`define LSE_RISE_LO        0
`define LSE_DLY_MS_0       7'h00
`define LSE_DLY_MS_1       7'h02
`define LSE_DLY_MS_2       7'h04
`define LSE_DLY_MS_3       7'h08
`define LSE_DLY_MS_4       7'h10
`define LSE_DLY_MS_5       7'h18
`define LSE_DLY_MS_6       7'h20
`define LSE_DLY_MS_7       7'h40
`define LSE_CLK_MHZ        100
`define LSE_TICK_US        1000
`define LSE_TICK_CYCLES    (`LSE_TICK_US * `LSE_CLK_MHZ)
`define LSE_PRE_W          24
`define LSE_MS_W           7
`define LSE_SYNC_W         16
`endif

//--- rtl/lse_pkg.sv
// types and delay decode shared by the enable logic
`include "lse_map.svh"
package lse_pkg;

  typedef enum logic [2:0] {
    lse_src_pin1  = 3'h0,
    lse_src_pin2  = 3'h1,
    lse_src_pin5  = 3'h2,
    lse_src_pin4  = 3'h3,
    lse_src_pin3  = 3'h4,
    lse_src_pin34 = 3'h5,
    lse_src_pin6  = 3'h6,
    lse_src_one   = 3'h7
  } lse_src_type;

  typedef enum logic [1:0] {
    lse_pgt_1v5 = 2'h0,
    lse_pgt_1v8 = 2'h1,
    lse_pgt_2v5 = 2'h2,
    lse_pgt_3v3 = 2'h3
  } lse_pgt_type;

  typedef enum logic {lse_edge_idle, lse_edge_timing} lse_edge_state_type;

  typedef struct packed {
    lse_edge_state_type      state;
    logic                    out;
    logic [`LSE_PRE_W-1:0]   pre;
    logic [`LSE_MS_W-1:0]    ms;
    logic [`LSE_MS_W-1:0]    tgt;
  } lse_edge_st_type;

  typedef struct packed {
    logic [`LSE_SYNC_W-1:0]  s1;
    logic [`LSE_SYNC_W-1:0]  s2;
    logic [`LSE_SYNC_W-1:0]  s3;
    logic [`LSE_SYNC_W-1:0]  filt;
    logic [7:0]              pg_mask_a;
    logic [7:0]              pin_pg_cfg;
    logic [7:0]              edge_dly;
    logic [7:0]              rd_data;
    logic                    rd_valid;
    logic                    rail_en;
    logic                    second_en;
  } lse_top_st_type;

  function automatic logic [`LSE_MS_W-1:0] lse_delay_ms(
    input logic [2:0] code
  );
    logic [`LSE_MS_W-1:0] ms;
    ms = `LSE_DLY_MS_0;
    unique case (code)
      3'h0: ms = `LSE_DLY_MS_0;
      3'h1: ms = `LSE_DLY_MS_1;
      3'h2: ms = `LSE_DLY_MS_2;
      3'h3: ms = `LSE_DLY_MS_3;
      3'h4: ms = `LSE_DLY_MS_4;
      3'h5: ms = `LSE_DLY_MS_5;
      3'h6: ms = `LSE_DLY_MS_6;
      3'h7: ms = `LSE_DLY_MS_7;
    endcase
    return ms;
  endfunction : lse_delay_ms

endpackage : lse_pkg

//--- rtl/lse_edge_delay.sv
// edge delay timer for the selected enable source
`include "lse_map.svh"
module lse_edge_delay #(
  parameter int TICK_CYCLES = `LSE_TICK_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       src_in,
  input  wire logic [2:0] rise_code,
  input  wire logic [2:0] fall_code,
  output logic            delayed_out
);
  import lse_pkg::*;

  localparam logic [`LSE_PRE_W-1:0] PRE_END = `LSE_PRE_W'(TICK_CYCLES - 1);

  lse_edge_st_type      st_reg;
  lse_edge_st_type      st_next;
  logic [`LSE_MS_W-1:0] tgt_sel;
  logic [`LSE_MS_W-1:0] ms_inc;
  logic                 tick;

  always_comb begin
    st_next = st_reg;
    tgt_sel = src_in ? lse_delay_ms(rise_code) : lse_delay_ms(fall_code);
    ms_inc  = `LSE_MS_W'(st_reg.ms + 1'b1);
    tick    = (st_reg.pre == PRE_END);
    unique case (st_reg.state)
      lse_edge_idle: begin
        if (src_in != st_reg.out) begin
          if (tgt_sel == '0) begin
            st_next.out = src_in;
          end else begin
            st_next.state = lse_edge_timing;
            st_next.tgt   = tgt_sel;
            st_next.pre   = '0;
            st_next.ms    = '0;
          end
        end
      end
      lse_edge_timing: begin
        if (src_in == st_reg.out) begin
          st_next.state = lse_edge_idle;
        end else if (tick) begin
          st_next.pre = '0;
          st_next.ms  = ms_inc;
          if (ms_inc == st_reg.tgt) begin
            st_next.out   = src_in;
            st_next.state = lse_edge_idle;
          end
        end else begin
          st_next.pre = `LSE_PRE_W'(st_reg.pre + 1'b1);
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{state: lse_edge_idle, out: 1'b0, pre: '0, ms: '0, tgt: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign delayed_out = st_reg.out;

  property p_rise_load;
    @(posedge sys_clk) disable iff (rst)
    (st_reg.state == lse_edge_idle && src_in && !st_reg.out && rise_code != 0)
    |=> (st_reg.state == lse_edge_timing && !st_reg.out
         && st_reg.tgt == lse_delay_ms($past(rise_code)));
  endproperty
  a_rise_load: assert property (p_rise_load)
    else $error("rising delay not loaded");

  property p_fall_zero;
    @(posedge sys_clk) disable iff (rst)
    (st_reg.state == lse_edge_idle && !src_in && st_reg.out && fall_code == 0)
    |=> !delayed_out;
  endproperty
  a_fall_zero: assert property (p_fall_zero)
    else $error("zero falling delay did not pass through");

  property p_cancel;
    @(posedge sys_clk) disable iff (rst)
    (st_reg.state == lse_edge_timing && src_in == st_reg.out)
    |=> (st_reg.state == lse_edge_idle && $stable(delayed_out));
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("timing not abandoned on return to old level");

  property p_hold;
    @(posedge sys_clk) disable iff (rst)
    (st_reg.state == lse_edge_timing && !(tick && ms_inc == st_reg.tgt))
    |=> $stable(delayed_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output moved before delay expired");

endmodule : lse_edge_delay

//--- rtl/lse_top.sv
// enable qualification logic for the first b load switch
`include "lse_map.svh"
module lse_top #(
  parameter int TICK_CYCLES = `LSE_TICK_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               control_pin_one,
  input  wire logic               control_pin_two,
  input  wire logic               control_pin_three,
  input  wire logic               control_pin_four,
  input  wire logic               control_pin_five,
  input  wire logic               control_pin_six,
  input  wire logic [5:0]         buck_rail_power_good,
  input  wire logic               load_switch_a_first_power_good,
  input  wire logic               aux_ldo_second_power_good,
  input  wire logic               switch_b_second_or_ldo_one_power_good,
  input  wire logic               aux_ldo_third_power_good,
  input  wire logic               combine_switch_b_enables,
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr_en,
  input  wire logic [7:0]         reg_wr_data,
  input  wire logic               reg_rd_en,
  output logic [7:0]              reg_rd_data,
  output logic                    reg_rd_valid,
  output logic                    load_switch_b_first_enable,
  output logic                    load_switch_b_second_enable,
  output lse_pkg::lse_pgt_type    pg_threshold_select
);
  import lse_pkg::*;

  lse_top_st_type         st_reg;
  lse_top_st_type         st_next;
  logic [`LSE_SYNC_W-1:0] pin_vec;
  logic [5:0]             ctl_f;
  logic [5:0]             pg_buck_f;
  logic                   pg_swa_f;
  logic                   pg_ldo2_f;
  logic                   pg_swb2_f;
  logic                   pg_ldo3_f;
  logic                   m_ldo2;
  logic                   m_swa;
  logic [5:0]             m_buck;
  logic                   m_swb2;
  logic                   m_ldo3;
  lse_src_type            src_code;
  logic [2:0]             rise_code;
  logic [2:0]             fall_code;
  logic                   src_sel;
  logic                   dly_out;
  logic                   term_ldo2;
  logic                   term_swa;
  logic                   term_buck;
  logic                   term_swb2;
  logic                   term_ldo3;
  logic                   pg_ok;
  logic                   en_cond;
  logic [1:0]             wr_pgt;
  logic [`LSE_SYNC_W-1:0] sync_s2;
  logic [`LSE_SYNC_W-1:0] sync_s3;

  // asynchronous pins gathered for the three stage synchroniser
  assign pin_vec = {aux_ldo_third_power_good,
                    switch_b_second_or_ldo_one_power_good,
                    aux_ldo_second_power_good,
                    load_switch_a_first_power_good,
                    buck_rail_power_good,
                    control_pin_six,
                    control_pin_five,
                    control_pin_four,
                    control_pin_three,
                    control_pin_two,
                    control_pin_one};

  assign {pg_ldo3_f, pg_swb2_f, pg_ldo2_f, pg_swa_f, pg_buck_f, ctl_f} =
    st_reg.filt;

  assign sync_s2 = st_reg.s2;
  assign sync_s3 = st_reg.s3;

  assign m_ldo2    = st_reg.pg_mask_a[`LSE_BIT_MASK_LDO2];
  assign m_swa     = st_reg.pg_mask_a[`LSE_BIT_MASK_SWA];
  assign m_buck    = st_reg.pg_mask_a[`LSE_BUCK_HI:`LSE_BUCK_LO];
  assign m_swb2    = st_reg.pin_pg_cfg[`LSE_BIT_MASK_SWB2];
  assign m_ldo3    = st_reg.pin_pg_cfg[`LSE_BIT_MASK_LDO3];
  assign src_code  = lse_src_type'(st_reg.pin_pg_cfg[`LSE_SRC_HI:`LSE_SRC_LO]);
  assign rise_code = st_reg.edge_dly[`LSE_RISE_HI:`LSE_RISE_LO];
  assign fall_code = st_reg.edge_dly[`LSE_FALL_HI:`LSE_FALL_LO];
  assign wr_pgt    = reg_wr_data[`LSE_PGT_HI:`LSE_PGT_LO];

  // enable source multiplexer
  always_comb begin
    src_sel = 1'b0;
    unique case (src_code)
      lse_src_pin1:  src_sel = ctl_f[0];
      lse_src_pin2:  src_sel = ctl_f[1];
      lse_src_pin5:  src_sel = ctl_f[4];
      lse_src_pin4:  src_sel = ctl_f[3];
      lse_src_pin3:  src_sel = ctl_f[2];
      lse_src_pin34: src_sel = ctl_f[2] & ctl_f[3];
      lse_src_pin6:  src_sel = ctl_f[5];
      lse_src_one:   src_sel = 1'b1;
    endcase
  end

  lse_edge_delay #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_edge_delay (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .src_in      (src_sel),
    .rise_code   (rise_code),
    .fall_code   (fall_code),
    .delayed_out (dly_out)
  );

  // power good qualification
  assign term_ldo2 = m_ldo2 | pg_ldo2_f;
  assign term_swa  = m_swa | pg_swa_f;
  assign term_buck = &(m_buck | pg_buck_f);
  assign term_swb2 = m_swb2 | pg_swb2_f;
  assign term_ldo3 = m_ldo3 | pg_ldo3_f;
  assign pg_ok     = term_ldo2 & term_swa & term_buck & term_swb2 & term_ldo3;
  assign en_cond   = dly_out & pg_ok;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_vec;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.filt = ((st_reg.s2 ~^ st_reg.s3) & st_reg.s3)
                 | ((st_reg.s2 ^ st_reg.s3) & st_reg.filt);
    st_next.rail_en   = en_cond;
    st_next.second_en = combine_switch_b_enables & en_cond;
    st_next.rd_valid  = reg_rd_en;
    if (reg_wr_en) begin
      case (reg_addr)
        `LSE_OFS_PG_MASK_A:  st_next.pg_mask_a  = reg_wr_data;
        `LSE_OFS_PIN_PG_CFG: st_next.pin_pg_cfg = reg_wr_data;
        `LSE_OFS_EDGE_DLY:   st_next.edge_dly   = reg_wr_data;
        default: begin
        end
      endcase
    end
    if (reg_rd_en) begin
      case (reg_addr)
        `LSE_OFS_PG_MASK_A:  st_next.rd_data = st_reg.pg_mask_a;
        `LSE_OFS_PIN_PG_CFG: st_next.rd_data = st_reg.pin_pg_cfg;
        `LSE_OFS_EDGE_DLY:   st_next.rd_data = st_reg.edge_dly;
        default:             st_next.rd_data = `LSE_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{s1: '0, s2: '0, s3: '0, filt: '0,
                  pg_mask_a: `LSE_RST_PG_MASK_A,
                  pin_pg_cfg: `LSE_RST_PIN_PG_CFG,
                  edge_dly: `LSE_RST_EDGE_DLY,
                  rd_data: '0, rd_valid: 1'b0,
                  rail_en: 1'b0, second_en: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rd_data                 = st_reg.rd_data;
  assign reg_rd_valid                = st_reg.rd_valid;
  assign load_switch_b_first_enable  = st_reg.rail_en;
  assign load_switch_b_second_enable = st_reg.second_en;
  assign pg_threshold_select =
    lse_pgt_type'(st_reg.pin_pg_cfg[`LSE_PGT_HI:`LSE_PGT_LO]);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // a rise already timing keeps its latched delay, so wait for idle
  sequence s_const_on;
    (src_code == lse_src_one && rise_code == 3'h0 && pg_ok
     && u_edge_delay.st_reg.state == lse_edge_idle) [*3];
  endsequence

  property p_ldo2_gate;
    (!m_ldo2 && !pg_ldo2_f) |=> !load_switch_b_first_enable;
  endproperty
  a_ldo2_gate: assert property (p_ldo2_gate)
    else $error("enable high with unmasked aux ldo second pg low");

  property p_swa_gate;
    load_switch_b_first_enable |-> ($past(m_swa) || $past(pg_swa_f));
  endproperty
  a_swa_gate: assert property (p_swa_gate)
    else $error("enable high with unmasked switch a pg low");

  property p_buck_gate;
    (|(~m_buck & ~pg_buck_f)) |=> !load_switch_b_first_enable;
  endproperty
  a_buck_gate: assert property (p_buck_gate)
    else $error("enable high with an unmasked buck pg low");

  property p_swb2_ldo3_gate;
    load_switch_b_first_enable |->
      $past(term_swb2) && $past(m_ldo3 || pg_ldo3_f);
  endproperty
  a_swb2_ldo3_gate: assert property (p_swb2_ldo3_gate)
    else $error("enable high with unmasked second switch or ldo third pg low");

  property p_src_pin5;
    (src_code == lse_src_pin5) |-> (src_sel == ctl_f[4]);
  endproperty
  a_src_pin5: assert property (p_src_pin5)
    else $error("source code 010 not routed to pin five");

  property p_src_pair;
    (src_code == lse_src_pin34) |-> (src_sel == (ctl_f[2] && ctl_f[3]));
  endproperty
  a_src_pair: assert property (p_src_pair)
    else $error("source code 101 not the and of pins three and four");

  property p_const_on;
    s_const_on |=> load_switch_b_first_enable;
  endproperty
  a_const_on: assert property (p_const_on)
    else $error("constant source did not enable the rail");

  property p_threshold_write;
    (reg_wr_en && reg_addr == `LSE_OFS_PIN_PG_CFG)
    |=> (pg_threshold_select == lse_pgt_type'($past(wr_pgt)));
  endproperty
  a_threshold_write: assert property (p_threshold_write)
    else $error("threshold code not taken from write");

  property p_combine;
    $past(combine_switch_b_enables) |->
      (load_switch_b_second_enable == load_switch_b_first_enable);
  endproperty
  a_combine: assert property (p_combine)
    else $error("second switch enable does not follow the first");

  property p_no_combine;
    !$past(combine_switch_b_enables) |-> !load_switch_b_second_enable;
  endproperty
  a_no_combine: assert property (p_no_combine)
    else $error("second switch enabled without combine");

  property p_enable_cause;
    ##1 (load_switch_b_first_enable == $past(en_cond));
  endproperty
  a_enable_cause: assert property (p_enable_cause)
    else $error("enable differs from delayed source and power good");

  property p_filter_agree;
    !$stable(st_reg.filt) |->
      ((($past(sync_s2) ~^ $past(sync_s3))
        | ~(st_reg.filt ^ $past(st_reg.filt))) == '1);
  endproperty
  a_filter_agree: assert property (p_filter_agree)
    else $error("filtered pin changed before stages agreed");

  property p_read_answer;
    reg_rd_en |=> reg_rd_valid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered one cycle later");

  property p_src_pin1;
    (src_code == lse_src_pin1) |-> (src_sel == ctl_f[0]);
  endproperty
  a_src_pin1: assert property (p_src_pin1)
    else $error("source code 000 not routed to pin one");

  property p_src_pin6;
    (src_code == lse_src_pin6) |-> (src_sel == ctl_f[5]);
  endproperty
  a_src_pin6: assert property (p_src_pin6)
    else $error("source code 110 not routed to pin six");

  property p_src_one;
    (src_code == lse_src_one) |-> src_sel;
  endproperty
  a_src_one: assert property (p_src_one)
    else $error("source code 111 did not select constant one");

  property p_mask_write;
    (reg_wr_en && reg_addr == `LSE_OFS_PG_MASK_A)
    |=> (st_reg.pg_mask_a == $past(reg_wr_data));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("power good mask write not stored");

  property p_delay_write;
    (reg_wr_en && reg_addr == `LSE_OFS_EDGE_DLY)
    |=> (st_reg.edge_dly == $past(reg_wr_data));
  endproperty
  a_delay_write: assert property (p_delay_write)
    else $error("edge delay write not stored");

  property p_read_cfg;
    (reg_rd_en && reg_addr == `LSE_OFS_PIN_PG_CFG)
    |=> (reg_rd_data == $past(st_reg.pin_pg_cfg));
  endproperty
  a_read_cfg: assert property (p_read_cfg)
    else $error("read of pin and pg config returned wrong value");

  property p_read_unmapped;
    (reg_rd_en && !(reg_addr inside {`LSE_OFS_PG_MASK_A,
                                     `LSE_OFS_PIN_PG_CFG,
                                     `LSE_OFS_EDGE_DLY}))
    |=> (reg_rd_data == `LSE_RD_UNMAPPED);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("read of unmapped address not zero");

  property p_second_on;
    (combine_switch_b_enables && en_cond) |=> load_switch_b_second_enable;
  endproperty
  a_second_on: assert property (p_second_on)
    else $error("second switch not enabled with combine set");

endmodule : lse_top

//--- verif/test_load_switch_enable_logic.sv
// self-checking bench for the load switch enable logic
`include "lse_map.svh"
module test_load_switch_enable_logic;
  timeunit 1ns;
  timeprecision 100ps;
  import lse_pkg::*;

  localparam int TICKS = 10;
  // three sync stages, filter, zero delay and enable register
  localparam int PIPE  = 6;
  logic              sys_clk;
  logic              rst;
  logic [5:0]        pins;
  logic [5:0]        buck_pg;
  logic              swa_pg;
  logic              ldo2_pg;
  logic              swb2_pg;
  logic              ldo3_pg;
  logic              combine;
  logic [7:0]        reg_addr;
  logic              reg_wr_en;
  logic [7:0]        reg_wr_data;
  logic              reg_rd_en;
  logic [7:0]        reg_rd_data;
  logic              reg_rd_valid;
  logic              en_first;
  logic              en_second;
  lse_pgt_type       pgt;
  int                n_errors = 0;
  int                checked = 0;
  int                seed = 33369;
  int                sel_pin[8] = '{0, 1, 4, 3, 2, 0, 5, 0};
  int                ms_tab[8] = '{0, 2, 4, 8, 16, 24, 32, 64};

  lse_top #(.TICK_CYCLES(TICKS)) dut_u (
    .sys_clk(sys_clk), .rst(rst),
    .control_pin_one(pins[0]), .control_pin_two(pins[1]),
    .control_pin_three(pins[2]), .control_pin_four(pins[3]),
    .control_pin_five(pins[4]), .control_pin_six(pins[5]),
    .buck_rail_power_good(buck_pg),
    .load_switch_a_first_power_good(swa_pg),
    .aux_ldo_second_power_good(ldo2_pg),
    .switch_b_second_or_ldo_one_power_good(swb2_pg),
    .aux_ldo_third_power_good(ldo3_pg),
    .combine_switch_b_enables(combine),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .load_switch_b_first_enable(en_first),
    .load_switch_b_second_enable(en_second),
    .pg_threshold_select(pgt)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic close_out();
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk_reg(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_en(string what, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_en

  task automatic chk_time(string what, int exp, int got, int tol);
    checked++;
    if (got > exp + tol || got < exp - tol) begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_time

  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    step(1);
    reg_wr_en = 1'b0;
    step(1);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    step(1);
    reg_rd_en = 1'b0;
    chk_en("rd_valid", 1'b1, reg_rd_valid);
    chk_reg("rd_data", exp, reg_rd_data);
    step(1);
    chk_en("rd_valid", 1'b0, reg_rd_valid);
  endtask : rd

  task automatic wait_en(logic lvl, output int n);
    n = 0;
    while (en_first !== lvl) begin
      if (n == 1000) begin
        n_errors++;
        $display("[FAIL] enable wait expected %b seen %b", lvl, en_first);
        close_out();
      end
      step(1);
      n++;
    end
  endtask : wait_en

  function automatic logic src_model(int code, logic [5:0] p);
    if (code == 7) return 1'b1;
    if (code == 5) return p[2] & p[3];
    return p[sel_pin[code]];
  endfunction : src_model

  initial begin
    int n;
    logic [7:0] d;
    logic [7:0] ma;
    logic [1:0] mb;
    logic e;
    logic hi;
    sys_clk = 1'b0;
    rst = 1'b1;
    pins = '0;
    {buck_pg, swa_pg, ldo2_pg, swb2_pg, ldo3_pg} = '1;
    combine = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h80);
    rd(8'h24, 8'h00);
    chk_reg("threshold", 8'h00, {6'h00, pgt});
    chk_en("first_enable", 1'b0, en_first);
    wr(8'h25, 8'h5a);
    rd(8'h25, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      wr(8'h22 + 8'(i), d);
      rd(8'h22 + 8'(i), d);
    end
    wr(8'h22, 8'h00);
    wr(8'h24, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'h23, {3'h0, 3'(c), 2'h0});
      repeat (6) begin
        pins = 6'($random(seed));
        combine = 1'($random(seed));
        step(8);
        e = src_model(c, pins);
        chk_en("first_enable", e, en_first);
        chk_en("second_enable", e & combine, en_second);
      end
    end
    for (int i = 0; i < 24; i++) begin
      ma = 8'($random(seed));
      mb = 2'($random(seed));
      d = {1'($random(seed)), 2'($random(seed)), 3'h7, mb};
      {buck_pg, swa_pg, ldo2_pg, swb2_pg, ldo3_pg} =
        10'($random(seed)) | 10'($random(seed)) | 10'($random(seed));
      wr(8'h22, ma);
      wr(8'h23, d);
      chk_reg("threshold", {6'h00, d[6:5]}, {6'h00, pgt});
      step(6);
      e = &({ldo2_pg, swa_pg, buck_pg} | ma) & &({swb2_pg, ldo3_pg} | mb);
      chk_en("first_enable", e, en_first);
    end
    wr(8'h22, 8'hff);
    wr(8'h23, 8'h03);
    pins = '0;
    step(8);
    for (int k = 0; k < 8; k++) begin
      wr(8'h24, {2'h0, 3'(k), 3'(k)});
      pins[0] = 1'b1;
      wait_en(1'b1, n);
      chk_time("rise_delay", PIPE + ms_tab[k] * TICKS, n, ms_tab[k]);
      pins[0] = 1'b0;
      wait_en(1'b0, n);
      chk_time("fall_delay", PIPE + ms_tab[k] * TICKS, n, ms_tab[k]);
    end
    wr(8'h24, 8'h02);
    pins[0] = 1'b1;
    step(20);
    pins[0] = 1'b0;
    hi = 1'b0;
    repeat (60) begin
      step(1);
      hi = hi | en_first;
    end
    chk_en("aborted_rise", 1'b0, hi);
    pins[0] = 1'b1;
    wait_en(1'b1, n);
    chk_time("restart_delay", PIPE + 4 * TICKS, n, 4);
    close_out();
  end
endmodule : test_load_switch_enable_logic
